// File: arc_host_model.sv
`timescale 1ns/1ps
// Host: free-running master clock; counts strobes past the settle window.
module arc_host_model #(
  parameter int DISCARD = 48 // Cycles to ignore after release
) (
  input  wire logic ref_clk,  // System clock
  input  wire logic pin_n,    // Reset pin level
  input  wire logic strobe_n, // Strobe wire
  output logic      mclk,     // Master clock
  output int        kept      // Strobes accepted
);
  int age;
  initial begin
    mclk = 1'b0;
    forever #32 mclk = ~mclk;
  end
  always @(posedge ref_clk) begin
    age  <= pin_n ? age + 1 : 0;
    kept <= !pin_n ? 0 : kept + int'(strobe_n === 1'b0 && age > DISCARD);
  end
endmodule

// File: arc_pkg.sv
package arc_pkg;

  // ----------------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------------
  localparam int          TRIM_LSB        = 0;
  localparam int          TRIM_MSB        = 7;
  localparam logic [7:0]  TRIM_RESET      = 8'h50;
  localparam logic        EXTREF_RESET    = 1'h0;
  localparam logic [3:0]  COMP_RESET_PAT  = 4'h3;
  localparam logic [23:0] CODE_RESET      = 24'h000000;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ     = 200;
  localparam int SETTLE_US   = 1000;
  localparam int SETTLE_CYC  = SETTLE_US * CLK_MHZ;
  localparam int FILT_DMCLK  = 3;
  localparam int AZ_PHASES   = 4;

  typedef enum logic [1:0] {
    ARC_HOLD,
    ARC_SETTLE,
    ARC_RUN
  } arc_mode_e;

  typedef struct packed {
    logic       ext_ref;
    logic [7:0] trim;
  } arc_cfg_s;

  typedef struct packed {
    logic [23:0] code;
    logic        valid;
  } arc_chan_s;

endpackage

// File: arc_top.sv
`timescale 1ns/1ps

// Overview of operation
// - External reference select high turns reference pins into a differential input.
// - Eight-bit reference trim in first configuration register bits 7..0, default 0x50.
// - Reference buffer auto-zero steps with master clock rising edges.
// - After power-on reset, conversion strobes run with default configuration.
// - Reset pin low holds all channels in reset with zero output code.
// - Hard reset clears modulators and forces comparator pattern 0011.
// - Hard reset clears decimation filters and their double output buffers.
// - Reset pin acts independently of SPI and restores register defaults.
// - Reset pin low ignores SPI writes, registers unchanged.
// - Reset pin low tri-states serial data output and conversion strobe.
// - Bias stays powered during hard reset; conversion resumes after the filter settling window.
module arc_top #(
  parameter int NCH        = 8,
  parameter int OSR        = 256,
  parameter int DMCLK_DIV  = 4
) (
  input  wire logic               ref_clk,          // 200 MHz system clock
  input  wire logic               rst,              // Asynchronous power-on reset
  input  wire logic               hard_reset_n,     // Reset pin, active low
  input  wire logic               mclk,             // Master clock pin
  input  wire logic               spi_wr,           // SPI write strobe for config
  input  wire arc_pkg::arc_cfg_s  spi_wdata,        // SPI write data
  input  wire logic [NCH-1:0]     mod_bit,          // Modulator bitstreams
  input  wire logic               sdo_data,         // Serial data from SPI engine
  output logic                    ref_pin_drive_oe, // Drive internal ref onto pin
  output logic                    ref_diff_in_en,   // Reference pins as diff input
  output arc_pkg::arc_cfg_s       cfg_out,          // Configuration register
  output logic [1:0]              az_phase,         // Reference buffer auto-zero phase
  output logic [NCH*4-1:0]        comp_out,         // Comparator outputs per channel
  output logic [NCH*24-1:0]       chan_code,        // Channel output codes
  output logic                    bias_on,          // Bias circuits powered
  output logic                    sdo_o,            // Serial data out
  output logic                    sdo_oe,           // Serial data enable
  output logic                    conversion_done_strobe_n, // Strobe, active low
  output logic                    strobe_oe         // Strobe enable
);

  localparam int SETTLE_OSR = OSR * arc_pkg::FILT_DMCLK * DMCLK_DIV;

  typedef struct packed {
    logic [2:0]          rsync;
    logic [2:0]          msync;
    logic                mclk_lvl;
    arc_pkg::arc_cfg_s   cfg;
    arc_pkg::arc_mode_e  mode;
    logic [31:0]         cnt;
    logic [1:0]          az;
    logic [NCH*4-1:0]    comp;
    logic [NCH*24-1:0]   acc;
    logic [NCH*24-1:0]   obuf;
    logic                strobe_n;
    logic                oe;
    logic                sdo;
    logic                drv_oe;
  } arc_state_s;

  arc_state_s s_q, s_d;
  logic       rpin_low;
  logic       rpin_stable;
  logic       mclk_rise;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rsync = {s_q.rsync[1:0], hard_reset_n};
    s_d.msync = {s_q.msync[1:0], mclk};
    rpin_stable = (s_q.rsync[2] == s_q.rsync[1]);
    rpin_low = rpin_stable ? !s_q.rsync[1] : (s_q.mode == arc_pkg::ARC_HOLD);
    mclk_rise = 1'b0;
    if (s_q.msync[2] == s_q.msync[1]) begin
      s_d.mclk_lvl = s_q.msync[1];
      mclk_rise = s_q.msync[1] && !s_q.mclk_lvl;
    end
    if (mclk_rise) begin
      s_d.az = s_q.az + 2'h1;
    end
    s_d.sdo = sdo_data;
    if (rpin_low) begin
      s_d.cfg.ext_ref = arc_pkg::EXTREF_RESET;
      s_d.cfg.trim = arc_pkg::TRIM_RESET;
      s_d.mode = arc_pkg::ARC_HOLD;
      s_d.cnt = 32'h0;
      s_d.comp = {NCH{arc_pkg::COMP_RESET_PAT}};
      s_d.acc = '0;
      s_d.obuf = '0;
      s_d.strobe_n = 1'b1;
      s_d.oe = 1'b0;
    end else begin
      s_d.oe = 1'b1;
      if (spi_wr) begin
        s_d.cfg = spi_wdata;
      end
      s_d.strobe_n = 1'b1;
      if (mclk_rise) begin
        for (int i = 0; i < NCH; i++) begin
          s_d.comp[i*4 +: 4] = {s_q.comp[i*4 +: 3], mod_bit[i]};
          s_d.acc[i*24 +: 24] = s_q.acc[i*24 +: 24] + {23'h0, mod_bit[i]};
        end
      end
      unique case (s_q.mode)
        arc_pkg::ARC_HOLD: begin
          s_d.mode = arc_pkg::ARC_SETTLE;
          s_d.cnt = 32'h0;
        end
        arc_pkg::ARC_SETTLE: begin
          s_d.cnt = s_q.cnt + 32'h1;
          if (s_q.cnt >= 32'(SETTLE_OSR - 1)) begin
            s_d.mode = arc_pkg::ARC_RUN;
            s_d.cnt = 32'h0;
          end
        end
        arc_pkg::ARC_RUN: begin
          s_d.cnt = s_q.cnt + 32'h1;
          if (s_q.cnt >= 32'(OSR * DMCLK_DIV - 1)) begin
            s_d.cnt = 32'h0;
            s_d.obuf = s_q.acc;
            s_d.acc = '0;
            s_d.strobe_n = 1'b0;
          end
        end
      endcase
    end
    // Registered so the reference pin driver never sees a combinational glitch.
    s_d.drv_oe = !s_d.cfg.ext_ref;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{rsync: 3'h0, msync: 3'h0, mclk_lvl: 1'b0,
               cfg: '{ext_ref: arc_pkg::EXTREF_RESET, trim: arc_pkg::TRIM_RESET},
               mode: arc_pkg::ARC_HOLD, cnt: 32'h0, az: 2'h0,
               comp: {NCH{arc_pkg::COMP_RESET_PAT}}, acc: '0, obuf: '0,
               strobe_n: 1'b1, oe: 1'b0, sdo: 1'b0, drv_oe: !arc_pkg::EXTREF_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  // Bias is never removed by the reset pin, only by power loss.
  assign bias_on = 1'b1;
  assign ref_diff_in_en = s_q.cfg.ext_ref;
  assign ref_pin_drive_oe = s_q.drv_oe;
  assign cfg_out = s_q.cfg;
  assign az_phase = s_q.az;
  assign comp_out = s_q.comp;
  assign chan_code = s_q.obuf;
  assign sdo_o = s_q.sdo;
  assign sdo_oe = s_q.oe;
  assign conversion_done_strobe_n = s_q.strobe_n;
  assign strobe_oe = s_q.oe;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence pin_low_seen;
    !s_q.rsync[1] && !s_q.rsync[2];
  endsequence

  trim_default_a: assert property (@(posedge ref_clk) disable iff (rst)
    pin_low_seen |=> s_q.cfg.trim == arc_pkg::TRIM_RESET)
    else $error("trim not restored to default");
  code_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    pin_low_seen |=> chan_code == '0)
    else $error("channel code not zero in reset");
  comp_pattern_a: assert property (@(posedge ref_clk) disable iff (rst)
    pin_low_seen |=> comp_out == {NCH{arc_pkg::COMP_RESET_PAT}})
    else $error("comparator pattern wrong in reset");
  outputs_hiz_a: assert property (@(posedge ref_clk) disable iff (rst)
    pin_low_seen |=> !sdo_oe && !strobe_oe)
    else $error("outputs driven in reset");
  write_blocked_a: assert property (@(posedge ref_clk) disable iff (rst)
    pin_low_seen ##1 pin_low_seen |=> $stable(cfg_out))
    else $error("config changed in reset");
  ref_select_a: assert property (@(posedge ref_clk) disable iff (rst)
    ref_diff_in_en != ref_pin_drive_oe)
    else $error("reference pin mode inconsistent");
  no_early_strobe_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.mode == arc_pkg::ARC_SETTLE |-> conversion_done_strobe_n)
    else $error("strobe before filter settled");
  filter_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    pin_low_seen |=> s_q.acc == '0)
    else $error("filter not cleared in reset");
  az_step_a: assert property (@(posedge ref_clk) disable iff (rst)
    !mclk_rise |=> $stable(az_phase))
    else $error("auto-zero stepped without master clock");

  sequence pin_high_seen;
    s_q.rsync[1] && s_q.rsync[2];
  endsequence

  // Settling must run its whole window, so the last count is checked on exit.
  sequence settle_done;
    $past(s_q.mode) == arc_pkg::ARC_SETTLE && s_q.mode == arc_pkg::ARC_RUN;
  endsequence

  outputs_on_a: assert property (@(posedge ref_clk) disable iff (rst)
    pin_high_seen |=> sdo_oe && strobe_oe)
    else $error("outputs not enabled after reset pin release");
  write_taken_a: assert property (@(posedge ref_clk) disable iff (rst)
    pin_high_seen ##0 spi_wr |=> cfg_out == $past(spi_wdata))
    else $error("config write lost while reset pin high");
  settle_len_a: assert property (@(posedge ref_clk) disable iff (rst)
    settle_done |-> $past(s_q.cnt) == 32'(SETTLE_OSR - 1))
    else $error("filter settling window wrong length");
  settle_step_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.mode == arc_pkg::ARC_SETTLE && $past(s_q.mode) == arc_pkg::ARC_SETTLE
      |-> s_q.cnt == $past(s_q.cnt) + 32'h1)
    else $error("settling counter skipped");
  strobe_width_a: assert property (@(posedge ref_clk) disable iff (rst)
    !conversion_done_strobe_n |=> conversion_done_strobe_n)
    else $error("strobe held longer than one cycle");
  az_wrap_a: assert property (@(posedge ref_clk) disable iff (rst)
    mclk_rise |=> az_phase == $past(az_phase) + 2'h1)
    else $error("auto-zero phase did not advance");

endmodule

// File: arc_top_tb.sv
`timescale 1ns/1ps
module arc_top_tb;
  logic              ref_clk, rst, pin_n, spi_wr, sdo_data, mclk;
  arc_pkg::arc_cfg_s wd, cfg, dflt;
  logic [7:0]        mod;
  logic              drv_oe, diff_en, bias, sdo_o, sdo_oe, str_n, str_oe;
  logic [1:0]        az, a0;
  logic [31:0]       comp;
  logic [191:0]      code;
  logic [8:0]        exp_cfg;
  int                bad_count, n_tests, cyc, kept, t, base, rises;
  logic [7:0]        msk;
  logic              ml;
  arc_top #(.NCH(8), .OSR(4), .DMCLK_DIV(4)) uut (.ref_clk(ref_clk), .rst(rst),
    .hard_reset_n(pin_n), .mclk(mclk), .spi_wr(spi_wr), .spi_wdata(wd), .mod_bit(mod),
    .sdo_data(sdo_data), .ref_pin_drive_oe(drv_oe), .ref_diff_in_en(diff_en),
    .cfg_out(cfg), .az_phase(az), .comp_out(comp), .chan_code(code), .bias_on(bias),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .conversion_done_strobe_n(str_n), .strobe_oe(str_oe));
  arc_host_model #(.DISCARD(48)) host (.ref_clk(ref_clk), .pin_n(pin_n),
    .strobe_n(str_oe ? str_n : 1'b1), .mclk(mclk), .kept(kept));
  assign dflt = {arc_pkg::EXTREF_RESET, arc_pkg::TRIM_RESET};
  task automatic chk(input logic [191:0] got, input logic [191:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Writes are refused while the pin is low, so the model follows the pin.
  task automatic wr(input logic [8:0] v);
    @(negedge ref_clk);
    spi_wr = 1'b1;
    wd     = v;
    if (pin_n) exp_cfg = v;
    @(negedge ref_clk);
    spi_wr = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rst_chk();
    chk(cfg, exp_cfg, "cfg default");
    chk(comp, {8{arc_pkg::COMP_RESET_PAT}}, "comparator");
    chk(code, {8{arc_pkg::CODE_RESET}}, "codes");
    chk({sdo_oe, str_oe, bias}, 3'b001, "oe bias");
  endtask
  // The pin synchroniser shifts the design's counting window by a few cycles
  // against the bench's, so one master clock rise either way is accepted.
  task automatic chk_code(input int n, input string m);
    int lo, hi;
    for (int i = 0; i < 8; i++) begin
      lo = (msk[i] && n > 0) ? n - 1 : 0;
      hi = msk[i] ? n + 1 : 0;
      n_tests++;
      if ((code[i*24 +: 24] inside {[lo:hi]}) !== 1'b1) begin
        bad_count++;
        $display("ERROR %0t %s", $time, m);
      end
    end
  endtask
  task automatic wait_strobe(output int w);
    w = 0;
    while (!(str_oe === 1'b1 && str_n === 1'b0) && w < 300) begin
      @(negedge ref_clk);
      w++;
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  always @(negedge ref_clk) begin
    mod      <= msk;
    sdo_data <= 1'($urandom);
    ml       <= mclk;
    if (mclk && !ml) begin
      rises <= rises + 1;
    end
  end
  initial begin
    t = $urandom(39);
    {rst, pin_n, spi_wr, wd, mod, sdo_data} = {2'b11, 19'h0};
    exp_cfg = 9'h050;
    msk     = 8'($urandom);
    repeat (10) @(negedge ref_clk);
    rst_chk();
    rst  = 1'b0;
    base = rises;
    chk(cfg, dflt, "readback after power up");
    wait_strobe(t);
    chk(t >= 48 && t < 300, 1, "first strobe after power on");
    chk_code(rises - base, "codes after power on");
    base = rises;
    @(negedge ref_clk);
    chk(str_n, 1'b1, "strobe width");
    wait_strobe(t);
    chk(t, 15, "strobe period");
    chk_code(rises - base, "codes in run");
    chk({sdo_oe, str_oe}, 2'b11, "outputs enabled");
    $display("test power on done");
    wr({1'b1, 8'($urandom)});
    chk(cfg, exp_cfg, "cfg write");
    chk({diff_en, drv_oe}, 2'b10, "external ref");
    wr({1'b0, 8'($urandom)});
    chk({diff_en, drv_oe}, 2'b01, "internal ref");
    chk(kept > 0, 1, "strobes after power on");
    a0 = az;
    repeat (30) @(negedge ref_clk);
    chk(az !== a0, 1, "auto zero phase");
    repeat (8) begin
      @(negedge ref_clk);
      chk(sdo_o, sdo_data, "serial data out");
    end
    $display("test config done");
    pin_n   = 1'b0;
    exp_cfg = dflt;
    msk     = 8'($urandom);
    repeat (6) @(negedge ref_clk);
    wr({1'b1, 8'hA5});
    rst_chk();
    $display("test hard reset done");
    pin_n = 1'b1;
    base  = rises;
    wait_strobe(t);
    chk(t >= 48 && t < 300, 1, "first strobe");
    chk_code(rises - base, "codes after release");
    @(negedge ref_clk);
    chk(str_n, 1'b1, "strobe width");
    chk(cfg, dflt, "cfg after release");
    $display("test release done");
    end_sim();
  end
endmodule
